// ===== core/lohpg_pkg.sv
// lohpg_pkg: register map, field layout, reset values and the gain table
// for the lineout-to-headphone gain register bank.
// assumes: used by lohpg_regs and tb; byte addresses are four times the index.

package lohpg_pkg;

  // ==========================================================================
  // register map
  localparam logic [5:0] LOHPG_IDX_LEFT    = 6'h1C;
  localparam logic [5:0] LOHPG_IDX_RIGHT   = 6'h1D;
  localparam logic [7:0] LOHPG_ADDR_LEFT   = {LOHPG_IDX_LEFT, 2'h0};
  localparam logic [7:0] LOHPG_ADDR_RIGHT  = {LOHPG_IDX_RIGHT, 2'h0};

  // ==========================================================================
  // fields and reset values
  localparam int         LOHPG_TOP_BIT     = 7;
  localparam int         LOHPG_CODE_MSB    = 6;
  localparam logic [6:0] LOHPG_CODE_RST    = 7'h7F;
  localparam logic [6:0] LOHPG_CODE_DISC   = 7'h7F;
  localparam logic [6:0] LOHPG_CODE_LAST   = 7'h75;
  localparam logic       LOHPG_GANG_RST    = 1'h0;
  localparam logic       LOHPG_TOP_LEFT    = 1'h0;

  // ==========================================================================
  // avalon answers
  localparam logic [1:0] LOHPG_RESP_OKAY   = 2'h0;
  localparam logic [1:0] LOHPG_RESP_DECERR = 2'h3;

  // ==========================================================================
  // attenuation in tenths of a dB, one entry per usable code
  localparam logic [9:0] LOHPG_ATTEN [0:117] = '{
    10'd0,   10'd5,   10'd10,  10'd15,  10'd20,  10'd25,  10'd30,  10'd35,
    10'd40,  10'd45,  10'd50,  10'd55,  10'd60,  10'd65,  10'd70,  10'd75,
    10'd80,  10'd85,  10'd90,  10'd95,  10'd100, 10'd105, 10'd110, 10'd115,
    10'd120, 10'd125, 10'd130, 10'd135, 10'd141, 10'd146, 10'd151, 10'd156,
    10'd160, 10'd165, 10'd171, 10'd175, 10'd181, 10'd186, 10'd191, 10'd196,
    10'd201, 10'd206, 10'd211, 10'd216, 10'd221, 10'd226, 10'd231, 10'd236,
    10'd241, 10'd246, 10'd251, 10'd256, 10'd261, 10'd266, 10'd271, 10'd276,
    10'd281, 10'd286, 10'd291, 10'd296, 10'd301, 10'd306, 10'd311, 10'd316,
    10'd321, 10'd327, 10'd331, 10'd336, 10'd341, 10'd346, 10'd352, 10'd357,
    10'd361, 10'd367, 10'd371, 10'd377, 10'd382, 10'd387, 10'd392, 10'd397,
    10'd402, 10'd407, 10'd412, 10'd418, 10'd421, 10'd427, 10'd432, 10'd438,
    10'd443, 10'd448, 10'd452, 10'd458, 10'd462, 10'd467, 10'd474, 10'd479,
    10'd482, 10'd487, 10'd493, 10'd500, 10'd503, 10'd510, 10'd514, 10'd518,
    10'd523, 10'd527, 10'd537, 10'd542, 10'd554, 10'd567, 10'd583, 10'd602,
    10'd627, 10'd643, 10'd662, 10'd687, 10'd723, 10'd783
  };
  localparam logic [9:0] LOHPG_ATTEN_NONE  = 10'h000;

endpackage

// ===== core/lohpg_regs.sv
// lohpg_regs: lineout-to-headphone gain register bank on an avalon-mm slave.
// assumes: master holds each request until it sees waitrequest low; clk is
// 100 MHz; srst synchronous.
//
// Functional notes
// - left register top bit reads zero, ignores writes; software writes zero
// - left register bits six to zero hold a code, reset all ones
// - code zero is 0 dB; codes up to 0x75 map to fixed table attenuations
// - left all-ones code disconnects left line output from left headphone driver
// - right top bit set applies left code to both channels; resets zero
// - right register bits six to zero hold a code, reset all ones
// - with gang clear, right all-ones code disconnects right line output from right driver

`timescale 1ns/100ps
`default_nettype none

module lohpg_regs
  import lohpg_pkg::*;
(
  // clock, reset, enable
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        ce,
  // avalon-mm slave
  input  wire logic [7:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output var  logic [31:0] readdata,
  output var  logic [1:0]  response,
  output var  logic        waitrequest,
  // gain selects toward the analogue drivers
  output var  logic [6:0]  left_headphone_driver_code,
  output var  logic [6:0]  right_headphone_driver_code,
  output var  logic        left_line_output_routed,
  output var  logic        right_line_output_routed,
  output var  logic [9:0]  left_atten_tenths,
  output var  logic [9:0]  right_atten_tenths
);

  // ==========================================================================
  // state
  typedef struct packed {
    logic [6:0]  left_code;
    logic [6:0]  right_code;
    logic        gang;
    logic        waitreq;
    logic [31:0] rdata;
    logic [1:0]  resp;
    logic [6:0]  left_sel;
    logic [6:0]  right_sel;
    logic        left_on;
    logic        right_on;
    logic [9:0]  left_att;
    logic [9:0]  right_att;
  } lohpg_state_t;

  lohpg_state_t st;
  lohpg_state_t next_st;

  logic req;
  logic done;
  logic hit_left;
  logic hit_right;

  assign req       = read | write;
  assign done      = req & ~st.waitreq;
  assign hit_left  = (address == LOHPG_ADDR_LEFT);
  assign hit_right = (address == LOHPG_ADDR_RIGHT);

  // ==========================================================================
  // next state
  always_comb
  begin
    next_st = st;
    // one wait cycle per access; read data is latched in that wait cycle
    if (req && st.waitreq)
    begin
      next_st.waitreq = 1'h0;
      next_st.rdata   = 32'h0000_0000;
      next_st.resp    = LOHPG_RESP_OKAY;
      if (hit_left)
      begin
        next_st.rdata[7:0] = {LOHPG_TOP_LEFT, st.left_code};
      end
      else if (hit_right)
      begin
        next_st.rdata[7:0] = {st.gang, st.right_code};
      end
      else
      begin
        next_st.resp = LOHPG_RESP_DECERR;
      end
    end
    else if (done)
    begin
      next_st.waitreq = 1'h1;
    end
    // writes land only at the completing edge; reads change nothing
    if (done && write && byteenable[0])
    begin
      if (hit_left)
      begin
        next_st.left_code = writedata[LOHPG_CODE_MSB:0];
      end
      else if (hit_right)
      begin
        next_st.gang       = writedata[LOHPG_TOP_BIT];
        next_st.right_code = writedata[LOHPG_CODE_MSB:0];
      end
    end
    // derived selects follow the new register values on the same edge
    next_st.left_sel  = next_st.left_code;
    next_st.right_sel = next_st.gang ? next_st.left_code : next_st.right_code;
    // reserved codes are treated as disconnected as well, the safe side
    next_st.left_on   = (next_st.left_sel <= LOHPG_CODE_LAST);
    next_st.right_on  = (next_st.right_sel <= LOHPG_CODE_LAST);
    next_st.left_att  = next_st.left_on ? LOHPG_ATTEN[next_st.left_sel]
                                        : LOHPG_ATTEN_NONE;
    next_st.right_att = next_st.right_on ? LOHPG_ATTEN[next_st.right_sel]
                                         : LOHPG_ATTEN_NONE;
  end

  // ==========================================================================
  // registers
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      st            <= '0;
      st.left_code  <= LOHPG_CODE_RST;
      st.right_code <= LOHPG_CODE_RST;
      st.gang       <= LOHPG_GANG_RST;
      st.waitreq    <= 1'h1;
      st.left_sel   <= LOHPG_CODE_DISC;
      st.right_sel  <= LOHPG_CODE_DISC;
      st.left_on    <= 1'h0;
      st.right_on   <= 1'h0;
    end
    else if (ce)
    begin
      st <= next_st;
    end
  end

  assign readdata                    = st.rdata;
  assign response                    = st.resp;
  assign waitrequest                 = st.waitreq;
  assign left_headphone_driver_code  = st.left_sel;
  assign right_headphone_driver_code = st.right_sel;
  assign left_line_output_routed     = st.left_on;
  assign right_line_output_routed    = st.right_on;
  assign left_atten_tenths           = st.left_att;
  assign right_atten_tenths          = st.right_att;

  // ==========================================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence seq_write_done(logic [7:0] a);
    ce && write && byteenable[0] && !waitrequest && address == a;
  endsequence

  sequence seq_read_done;
    ce && read && !waitrequest;
  endsequence

  chk_left_top_zero: assert property (
    (ce && read && waitrequest && address == LOHPG_ADDR_LEFT) |=> readdata[7] == 1'h0)
    else $error("left top bit read back non-zero");

  chk_reset_disconnect: assert property (
    $past(srst) |-> (left_headphone_driver_code == 7'h7F && !left_line_output_routed
                     && right_headphone_driver_code == 7'h7F && !right_line_output_routed))
    else $error("bank not disconnected after reset");

  chk_zero_db: assert property (
    (left_headphone_driver_code == 7'h00) |-> (left_atten_tenths == 10'h000
                                              && left_line_output_routed))
    else $error("code zero is not 0 dB");

  chk_last_code: assert property (
    (right_headphone_driver_code == 7'h75) |-> right_atten_tenths == 10'h30F)
    else $error("code 0x75 is not 78.3 dB");

  chk_gang_follows: assert property (
    st.gang |-> right_headphone_driver_code == left_headphone_driver_code)
    else $error("gang set but right select differs from left");

  chk_left_write: assert property (
    seq_write_done(LOHPG_ADDR_LEFT) |=>
      left_headphone_driver_code == $past(writedata[6:0]))
    else $error("left write did not reach the select on the next edge");

  chk_right_write: assert property (
    seq_write_done(LOHPG_ADDR_RIGHT) ##0 !writedata[7] |=>
      right_headphone_driver_code == $past(writedata[6:0]))
    else $error("right write did not reach the select on the next edge");

  chk_left_disc: assert property (
    (left_headphone_driver_code == 7'h7F) |-> !left_line_output_routed)
    else $error("left all-ones code still routed");

  chk_right_disc: assert property (
    (right_headphone_driver_code == 7'h7F) |-> !right_line_output_routed)
    else $error("right all-ones code still routed");

  chk_read_quiet: assert property (
    seq_read_done |=> ($stable(left_headphone_driver_code)
                       && $stable(right_headphone_driver_code)))
    else $error("read changed a gain select");

  chk_one_wait: assert property (
    (ce && (read || write) && waitrequest) |=> !waitrequest ##1 (waitrequest || !ce))
    else $error("access did not complete after one wait cycle");

  // ==========================================================================
  // checks on read data, answers and the derived selects
  sequence seq_wait_cycle(logic [7:0] a);
    ce && (read || write) && waitrequest && address == a;
  endsequence

  sequence seq_wait_unmapped;
    ce && (read || write) && waitrequest
      && address != LOHPG_ADDR_LEFT && address != LOHPG_ADDR_RIGHT;
  endsequence

  chk_left_read_code: assert property (
    seq_wait_cycle(LOHPG_ADDR_LEFT) |=>
      readdata[6:0] == left_headphone_driver_code)
    else $error("left read data differs from the stored code");

  chk_right_read_code: assert property (
    seq_wait_cycle(LOHPG_ADDR_RIGHT) ##0 !st.gang |=>
      readdata[7:0] == {1'h0, right_headphone_driver_code})
    else $error("right read data differs from the stored code");

  chk_right_read_gang: assert property (
    seq_wait_cycle(LOHPG_ADDR_RIGHT) ##0 st.gang |=> readdata[7] == 1'h1)
    else $error("gang bit not returned on a right read");

  chk_read_upper_zero: assert property (
    (ce && read && waitrequest) |=> readdata[31:8] == 24'h000000)
    else $error("read data above the register byte not zero");

  chk_unmapped_answer: assert property (
    seq_wait_unmapped |=> (response == LOHPG_RESP_DECERR
                           && readdata == 32'h0000_0000))
    else $error("unmapped access not answered with a decode error");

  chk_mapped_answer: assert property (
    (ce && (read || write) && waitrequest && (hit_left || hit_right)) |=>
      response == LOHPG_RESP_OKAY)
    else $error("mapped access not answered okay");

  chk_left_table: assert property (
    left_line_output_routed |->
      left_atten_tenths == LOHPG_ATTEN[left_headphone_driver_code])
    else $error("left attenuation differs from its table entry");

  chk_right_table: assert property (
    right_line_output_routed |->
      right_atten_tenths == LOHPG_ATTEN[right_headphone_driver_code])
    else $error("right attenuation differs from its table entry");

  chk_left_off_zero: assert property (
    !left_line_output_routed |-> left_atten_tenths == LOHPG_ATTEN_NONE)
    else $error("left attenuation not cleared while disconnected");

  chk_right_off_zero: assert property (
    !right_line_output_routed |-> right_atten_tenths == LOHPG_ATTEN_NONE)
    else $error("right attenuation not cleared while disconnected");

  chk_left_in_range: assert property (
    (left_headphone_driver_code <= LOHPG_CODE_LAST) |-> left_line_output_routed)
    else $error("left usable code not routed");

  chk_right_in_range: assert property (
    (right_headphone_driver_code <= LOHPG_CODE_LAST) |-> right_line_output_routed)
    else $error("right usable code not routed");

  chk_gang_write: assert property (
    seq_write_done(LOHPG_ADDR_RIGHT) ##0 writedata[7] |=>
      right_headphone_driver_code == $past(left_headphone_driver_code))
    else $error("gang write did not copy the left code to the right");

  chk_gang_left_write: assert property (
    seq_write_done(LOHPG_ADDR_LEFT) ##0 st.gang |=>
      right_headphone_driver_code == $past(writedata[6:0]))
    else $error("left write under gang did not reach the right select");

  // a frozen bank must not drift, or the drivers see a code nobody wrote
  chk_ce_freeze: assert property (
    !ce |=> ($stable(left_headphone_driver_code) && $stable(right_headphone_driver_code)
             && $stable(waitrequest) && $stable(readdata)))
    else $error("state changed while the clock enable was low");

  chk_lane_off: assert property (
    (ce && write && !byteenable[0] && !waitrequest) |=>
      ($stable(left_headphone_driver_code) && $stable(right_headphone_driver_code)))
    else $error("write with lane zero disabled changed a select");

endmodule

`default_nettype wire

// ===== tb/tb.sv
// tb: self-checking bench for lohpg_regs, avalon-mm reads and writes.
// assumes: lohpg_pkg compiled first; bench drives every port itself.
`timescale 1ns/100ps
`default_nettype none

module tb;
  import lohpg_pkg::*;
  // ==========================================================================
  // signals
  logic        clk, srst, ce, read, write;
  logic [7:0]  address;
  logic [31:0] writedata, readdata, rd;
  logic [3:0]  byteenable;
  logic [1:0]  response, rs;
  logic        waitrequest, lrt, rrt;
  logic [6:0]  lcode, rcode;
  logic [9:0]  latt, ratt;
  int          fails, tests_run;
  // only usable codes are written, never the reserved ones
  logic [6:0]  codes [5] = '{7'h00, 7'h1C, 7'h41, 7'h74, 7'h75};
  logic [9:0]  atts  [5] = '{10'h000, 10'h08D, 10'h147, 10'h2D3, 10'h30F};

  lohpg_regs DUT (.clk(clk), .srst(srst), .ce(ce), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .response(response), .waitrequest(waitrequest), .left_headphone_driver_code(lcode),
    .right_headphone_driver_code(rcode), .left_line_output_routed(lrt),
    .right_line_output_routed(rrt), .left_atten_tenths(latt), .right_atten_tenths(ratt));

  // ==========================================================================
  // tasks
  task give_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one access; waitrequest and read data are taken right at the rising edge, before
  // that edge updates anything, so the values seen are those that stood at the edge
  task bus(input logic wr, input logic [7:0] a, input logic [7:0] d, input logic [3:0] be);
    int n;
    n = 0;
    @(posedge clk);
    read       <= !wr;
    write      <= wr;
    address    <= a;
    writedata  <= {24'h000000, d};
    byteenable <= be;
    @(posedge clk);
    while (waitrequest !== 1'h0 && n < 50)
    begin
      @(posedge clk);
      n++;
    end
    if (n == 50)
    begin
      fails++;
      give_verdict();
    end
    rd = readdata;
    rs = response;
    read  <= 1'h0;
    write <= 1'h0;
  endtask

  // routed is expected only for codes up to the last table entry
  task outs(input logic [6:0] lc, input logic [6:0] rc, input logic [9:0] la,
            input logic [9:0] ra);
    @(negedge clk);
    chk("left code", {25'h0, lc}, {25'h0, lcode});
    chk("right code", {25'h0, rc}, {25'h0, rcode});
    chk("left routed", {31'h0, lc <= 7'h75}, {31'h0, lrt});
    chk("right routed", {31'h0, rc <= 7'h75}, {31'h0, rrt});
    chk("left atten", {22'h0, la}, {22'h0, latt});
    chk("right atten", {22'h0, ra}, {22'h0, ratt});
  endtask

  // ==========================================================================
  // clock and sequence
  initial
  begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  initial
  begin
    {srst, ce, read, write, address, writedata, byteenable} = '0;
    srst = 1'h1;
    fails = 0;
    tests_run = 0;
    repeat (16) @(posedge clk);
    srst <= 1'h0;
    ce   <= 1'h1;
    outs(7'h7F, 7'h7F, 10'h000, 10'h000);
    bus(1'h0, LOHPG_ADDR_LEFT, 8'h00, 4'hF);
    chk("left reset", 32'h7F, rd);
    bus(1'h0, LOHPG_ADDR_RIGHT, 8'h00, 4'hF);
    chk("right reset", 32'h7F, rd);
    for (int i = 0; i < 5; i++)
    begin
      bus(1'h1, LOHPG_ADDR_LEFT, {1'h0, codes[i]}, 4'hF);
      bus(1'h1, LOHPG_ADDR_RIGHT, {1'h0, codes[i]}, 4'hF);
      outs(codes[i], codes[i], atts[i], atts[i]);
      bus(1'h0, LOHPG_ADDR_LEFT, 8'h00, 4'hF);
      chk("left readback", {25'h0, codes[i]}, rd);
    end
    // gang: left -8.0 dB drives both, right keeps -24.1 dB in its register
    bus(1'h1, LOHPG_ADDR_LEFT, 8'h10, 4'hF);
    bus(1'h1, LOHPG_ADDR_RIGHT, 8'hB0, 4'hF);
    outs(7'h10, 7'h10, 10'h050, 10'h050);
    bus(1'h0, LOHPG_ADDR_RIGHT, 8'h00, 4'hF);
    chk("right gang readback", 32'hB0, rd);
    bus(1'h1, LOHPG_ADDR_RIGHT, 8'h30, 4'hF);
    outs(7'h10, 7'h30, 10'h050, 10'h0F1);
    bus(1'h1, LOHPG_ADDR_LEFT, 8'h7F, 4'hF);
    outs(7'h7F, 7'h30, 10'h000, 10'h0F1);
    bus(1'h1, LOHPG_ADDR_RIGHT, 8'h7F, 4'hF);
    outs(7'h7F, 7'h7F, 10'h000, 10'h000);
    // unmapped place and a write with lane 0 disabled change nothing
    bus(1'h0, 8'h78, 8'h00, 4'hF);
    chk("unmapped read", 32'h0, rd);
    chk("unmapped resp", 32'h3, {30'h0, rs});
    bus(1'h1, 8'h78, 8'h00, 4'hF);
    chk("unmapped write resp", 32'h3, {30'h0, rs});
    bus(1'h1, LOHPG_ADDR_LEFT, 8'h00, 4'hE);
    outs(7'h7F, 7'h7F, 10'h000, 10'h000);
    // clock enable low stalls a read
    @(posedge clk);
    ce <= 1'h0;
    fork
      bus(1'h0, LOHPG_ADDR_LEFT, 8'h00, 4'hF);
      begin
        repeat (4) @(negedge clk);
        chk("stalled wait", 32'h1, {31'h0, waitrequest});
        @(posedge clk);
        ce <= 1'h1;
      end
    join
    chk("stalled read", 32'h7F, rd);
    // second reset in mid-run restores disconnect and clears gang
    bus(1'h1, LOHPG_ADDR_RIGHT, 8'h85, 4'hF);
    bus(1'h1, LOHPG_ADDR_LEFT, 8'h05, 4'hF);
    srst <= 1'h1;
    repeat (2) @(posedge clk);
    srst <= 1'h0;
    outs(7'h7F, 7'h7F, 10'h000, 10'h000);
    bus(1'h0, LOHPG_ADDR_RIGHT, 8'h00, 4'hF);
    chk("right after reset", 32'h7F, rd);
    give_verdict();
  end
endmodule

`default_nettype wire
